// File: sck_params.svh
`ifndef SCK_PARAMS_SVH
`define SCK_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SCK_BA_W        3
`define SCK_A_W         15
`define SCK_NBANK       8
`define SCK_CNT_W       10

// ----------------------------------------------------------------
// Field positions and encodings
// ----------------------------------------------------------------
`define SCK_AP_BIT      10
`define SCK_BC_BIT      12
`define SCK_MR_BL_OTF   2'h1
`define SCK_MR_BL_BC4   2'h2
`define SCK_MR_RST      15'h0000

// ----------------------------------------------------------------
// Timing counts in clock cycles (nCK)
// ----------------------------------------------------------------
`define SCK_TCKE_NCK    10'h003
`define SCK_TXP_NCK     10'h003
`define SCK_TXS_NCK     10'h018
`define SCK_TXSDLL_NCK  10'h200
`define SCK_TWRSRX_NCK  10'h200
`define SCK_XS_CAP      10'h200
`define SCK_TMRD_NCK    10'h004
`define SCK_TMOD_NCK    10'h00C
`define SCK_TRP_NCK     10'h006
`define SCK_TRFC_NCK    10'h02C
`define SCK_SREF_NCK    10'h010
`define SCK_BL8_NCK     3'h4
`define SCK_BC4_NCK     3'h2

`endif

// File: sck_pkg.sv
package sck_pkg;

  // ----------------------------------------------------------------
  // Command codes: for codes 0 to 7 the low three bits are {ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    cmd_mrs = 4'h0, cmd_ref = 4'h1, cmd_pre = 4'h2, cmd_act = 4'h3,
    cmd_wr  = 4'h4, cmd_rd  = 4'h5, cmd_zq  = 4'h6, cmd_nop = 4'h7,
    cmd_sre = 4'h8, cmd_srx = 4'h9, cmd_pde = 4'hA, cmd_pdx = 4'hB
  } sck_cmd_t;

  // ----------------------------------------------------------------
  // Device states
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    st_idle    = 9'h001, st_active = 9'h002, st_read   = 9'h004,
    st_write   = 9'h008, st_prech  = 9'h010, st_refresh = 9'h020,
    st_pd_pre  = 9'h040, st_pd_act = 9'h080, st_self_ref = 9'h100
  } sck_dstate_t;

  // ----------------------------------------------------------------
  // Controller power states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    cs_up = 3'h1, cs_pd = 3'h2, cs_sr = 3'h4
  } sck_cstate_t;

  // Deselect decodes as no-operation
  function automatic sck_cmd_t sck_decode(input logic cs_n,
                                          input logic [2:0] rcw);
    if (cs_n)
      return cmd_nop;
    return sck_cmd_t'({1'b0, rcw});
  endfunction

endpackage

// File: sck_if.sv
`timescale 1ns/1ps
`include "sck_params.svh"

interface sck_if;
  logic                  reset_n;
  logic                  cke;
  logic                  cs_n;
  logic                  ras_n;
  logic                  cas_n;
  logic                  we_n;
  logic                  odt;
  logic [`SCK_BA_W-1:0]  ba;
  logic [`SCK_A_W-1:0]   addr;

  modport ctl (output reset_n, cke, cs_n, ras_n, cas_n, we_n, odt,
               output ba, addr);
  modport dev (input reset_n, cke, cs_n, ras_n, cas_n, we_n, odt,
               input ba, addr);
endinterface

// File: sck_dev.sv
`timescale 1ns/1ps
`include "sck_params.svh"

module sck_dev (
  input  logic                   clock,
  input  logic                   nrst,
  sck_if.dev                     mem,
  output sck_pkg::sck_dstate_t   state_o,
  output logic [`SCK_NBANK-1:0]  bank_open_o,
  output logic [2:0]             burst_left_o,
  output logic                   idle_o,
  output logic                   odt_en_o,
  output logic                   sref_tick_o
);
  import sck_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [`SCK_NBANK-1:0] bank_bit(
      input logic [`SCK_BA_W-1:0] b);
    return 8'h01 << b;
  endfunction

  function automatic logic [2:0] burst_cycles(input logic [1:0] mode,
                                              input logic bc);
    if (mode == `SCK_MR_BL_OTF)
      return bc ? `SCK_BL8_NCK : `SCK_BC4_NCK;
    if (mode == `SCK_MR_BL_BC4)
      return `SCK_BC4_NCK;
    return `SCK_BL8_NCK;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  sck_dstate_t               state_reg;
  sck_dstate_t               run_next;
  logic                      cke_prev_reg;
  logic [`SCK_NBANK-1:0]     bank_open_reg;
  logic [2:0]                burst_reg;
  logic                      burst_wr_reg;
  logic                      burst_ap_reg;
  logic [`SCK_BA_W-1:0]      burst_ba_reg;
  logic [`SCK_CNT_W-1:0]     timer_reg;
  logic [`SCK_CNT_W-1:0]     sref_cnt_reg;
  logic [`SCK_A_W-1:0]       mr_reg [0:3];
  logic                      idle_reg;
  logic                      odt_en_reg;
  logic                      sref_tick_reg;

  sck_cmd_t                  cmd;
  logic                      ce_fall;
  logic                      ce_rise;
  logic                      ce_high;
  logic                      nopish;
  logic                      quiet;
  logic                      bursting;
  logic                      idle_base;
  logic                      go;
  logic                      take_rw;
  logic                      ref_ok;
  logic                      pre_ok;
  logic                      act_ok;
  logic                      mrs_ok;
  logic                      pd_exit;
  logic                      sr_exit;
  logic                      sr_enter;
  logic [`SCK_NBANK-1:0]     ap_close;
  logic [`SCK_NBANK-1:0]     banks_after;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign cmd = sck_decode(mem.cs_n,
                          {mem.ras_n, mem.cas_n, mem.we_n});
  assign nopish    = (cmd == cmd_nop);
  assign ce_fall   = cke_prev_reg & ~mem.cke;
  assign ce_rise   = ~cke_prev_reg & mem.cke;
  assign ce_high   = cke_prev_reg & mem.cke;
  assign quiet     = state_reg inside {st_pd_pre, st_pd_act, st_self_ref};
  assign bursting  = (burst_reg != 3'h0);
  assign ap_close  = (bursting && burst_ap_reg && burst_reg == 3'h1) ?
                     bank_bit(burst_ba_reg) : 8'h00;
  assign banks_after = bank_open_reg &
                       ~((bursting && burst_ap_reg) ?
                         bank_bit(burst_ba_reg) : 8'h00);
  assign idle_base = (bank_open_reg == 8'h00) && !bursting &&
                     (timer_reg == 10'h000) && !quiet;
  // Commands other than power-down and self refresh entry and exit act only when clocked in, awake and timing met
  assign go      = ce_high && !quiet && (timer_reg == 10'h000);
  assign take_rw = go && (cmd == cmd_rd || cmd == cmd_wr) && !bursting &&
                   bank_open_reg[mem.ba];
  assign ref_ok  = go && (cmd == cmd_ref) && (bank_open_reg == 8'h00) &&
                   !bursting;
  assign pre_ok  = go && (cmd == cmd_pre);
  assign act_ok  = go && (cmd == cmd_act) && !bank_open_reg[mem.ba];
  assign mrs_ok  = go && (cmd == cmd_mrs) && idle_base && !mem.ba[2];
  assign pd_exit = (state_reg inside {st_pd_pre, st_pd_act}) &&
                   ce_rise && nopish;
  assign sr_exit = (state_reg == st_self_ref) && mem.cke;
  assign sr_enter = ce_fall && (cmd == cmd_ref) && idle_base;

  always_comb begin
    if (take_rw)
      run_next = (cmd == cmd_wr) ? st_write : st_read;
    else if (pre_ok)
      run_next = st_prech;
    else if (ref_ok)
      run_next = st_refresh;
    else if (bursting && burst_reg != 3'h1)
      run_next = state_reg;
    else if (timer_reg > 10'h001 &&
             (state_reg == st_prech || state_reg == st_refresh))
      run_next = state_reg;
    else if (|(bank_open_reg & ~ap_close) || act_ok)
      run_next = st_active;
    else
      run_next = st_idle;
  end

  // ----------------------------------------------------------------
  // Power state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge mem.reset_n) begin
    if (!mem.reset_n) begin
      state_reg <= st_idle;
    end else if (!nrst) begin
      state_reg <= st_idle;
    end else begin
      case (state_reg)
        st_pd_pre, st_pd_act: begin
          if (pd_exit)
            state_reg <= (|bank_open_reg) ? st_active : st_idle;
        end
        st_self_ref: begin
          if (sr_exit)
            state_reg <= st_idle;
        end
        st_idle, st_active, st_read, st_write, st_prech,
        st_refresh: begin
          if (sr_enter)
            state_reg <= st_self_ref;
          else if (ce_fall && nopish)
            state_reg <= (|banks_after) ? st_pd_act : st_pd_pre;
          else if (ce_high)
            state_reg <= run_next;
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // CKE history, idle flag, ODT gate, self refresh ticks
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge mem.reset_n) begin
    if (!mem.reset_n) begin
      cke_prev_reg  <= 1'b0;
      idle_reg      <= 1'b0;
      odt_en_reg    <= 1'b0;
      sref_cnt_reg  <= 10'h000;
      sref_tick_reg <= 1'b0;
    end else if (!nrst) begin
      cke_prev_reg  <= 1'b0;
      idle_reg      <= 1'b0;
      odt_en_reg    <= 1'b0;
      sref_cnt_reg  <= 10'h000;
      sref_tick_reg <= 1'b0;
    end else begin
      cke_prev_reg  <= mem.cke;
      idle_reg      <= idle_base && ce_high;
      odt_en_reg    <= mem.odt && !sr_enter &&
                       (state_reg != st_self_ref);
      sref_tick_reg <= 1'b0;
      if (state_reg == st_self_ref) begin
        if (sref_cnt_reg == `SCK_SREF_NCK - 10'h001) begin
          sref_cnt_reg  <= 10'h000;
          sref_tick_reg <= 1'b1;
        end else begin
          sref_cnt_reg <= sref_cnt_reg + 10'h001;
        end
      end else begin
        sref_cnt_reg <= 10'h000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bank tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge mem.reset_n) begin
    if (!mem.reset_n) begin
      bank_open_reg <= 8'h00;
    end else if (!nrst) begin
      bank_open_reg <= 8'h00;
    end else if (act_ok) begin
      bank_open_reg <= (bank_open_reg & ~ap_close) |
                       bank_bit(mem.ba);
    end else if (pre_ok) begin
      bank_open_reg <= mem.addr[`SCK_AP_BIT] ? 8'h00 :
                       (bank_open_reg & ~ap_close & ~bank_bit(mem.ba));
    end else begin
      bank_open_reg <= bank_open_reg & ~ap_close;
    end
  end

  // ----------------------------------------------------------------
  // Burst counter: nothing cuts a burst short
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge mem.reset_n) begin
    if (!mem.reset_n) begin
      burst_reg    <= 3'h0;
      burst_wr_reg <= 1'b0;
      burst_ap_reg <= 1'b0;
      burst_ba_reg <= 3'h0;
    end else if (!nrst) begin
      burst_reg    <= 3'h0;
      burst_wr_reg <= 1'b0;
      burst_ap_reg <= 1'b0;
      burst_ba_reg <= 3'h0;
    end else if (take_rw) begin
      burst_reg    <= burst_cycles(mr_reg[0][1:0],
                                   mem.addr[`SCK_BC_BIT]);
      burst_wr_reg <= (cmd == cmd_wr);
      burst_ap_reg <= mem.addr[`SCK_AP_BIT];
      burst_ba_reg <= mem.ba;
    end else if (bursting) begin
      burst_reg <= burst_reg - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Command and exit timing
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge mem.reset_n) begin
    if (!mem.reset_n) begin
      timer_reg <= 10'h000;
    end else if (!nrst) begin
      timer_reg <= 10'h000;
    end else if (sr_exit) begin
      timer_reg <= `SCK_TXS_NCK;
    end else if (pd_exit) begin
      // Keep a longer pending wait running
      timer_reg <= (timer_reg > `SCK_TXP_NCK) ? timer_reg - 10'h001 :
                   `SCK_TXP_NCK;
    end else if (pre_ok) begin
      timer_reg <= `SCK_TRP_NCK;
    end else if (ref_ok) begin
      timer_reg <= `SCK_TRFC_NCK;
    end else if (mrs_ok) begin
      timer_reg <= `SCK_TMOD_NCK;
    end else if (timer_reg != 10'h000) begin
      timer_reg <= timer_reg - 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge mem.reset_n) begin
    if (!mem.reset_n) begin
      for (int i = 0; i < 4; i++)
        mr_reg[i] <= `SCK_MR_RST;
    end else if (!nrst) begin
      for (int i = 0; i < 4; i++)
        mr_reg[i] <= `SCK_MR_RST;
    end else if (mrs_ok) begin
      mr_reg[mem.ba[1:0]] <= mem.addr;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign state_o      = state_reg;
  assign bank_open_o  = bank_open_reg;
  assign burst_left_o = burst_reg;
  assign idle_o       = idle_reg;
  assign odt_en_o     = odt_en_reg;
  assign sref_tick_o  = sref_tick_reg;

endmodule // sck_dev

// File: sck_ctl.sv
`timescale 1ns/1ps
`include "sck_params.svh"

module sck_ctl (
  input  logic                   clock,
  input  logic                   nrst,
  input  logic                   req_valid,
  input  sck_pkg::sck_cmd_t      req_cmd,
  input  logic [`SCK_BA_W-1:0]   req_ba,
  input  logic [`SCK_A_W-1:0]    req_addr,
  input  logic                   req_odt,
  output logic                   ack_o,
  output logic                   rej_o,
  output sck_pkg::sck_cstate_t   pstate_o,
  sck_if.ctl                     mem
);
  import sck_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  sck_cstate_t               pst_reg;
  logic                      rst_n_reg;
  logic                      cke_reg;
  logic                      cs_n_reg;
  logic [2:0]                rcw_reg;
  logic                      odt_reg;
  logic [`SCK_BA_W-1:0]      ba_reg;
  logic [`SCK_A_W-1:0]       addr_reg;
  logic [`SCK_CNT_W-1:0]     hold_reg;
  logic [`SCK_CNT_W-1:0]     xs_reg;
  logic [`SCK_CNT_W-1:0]     mrd_reg;
  logic [2:0]                bst_reg;
  logic [`SCK_NBANK-1:0]     open_reg;
  logic                      ack_reg;
  logic                      rej_reg;

  logic                      up;
  logic                      legal;
  logic                      take;
  logic                      cke_cmd;

  assign up      = (pst_reg == cs_up);
  assign cke_cmd = req_cmd inside {cmd_pde, cmd_pdx, cmd_sre, cmd_srx};

  // ----------------------------------------------------------------
  // Legality of the next request
  // ----------------------------------------------------------------
  always_comb begin
    case (req_cmd)
      cmd_nop: legal = 1'b1;
      cmd_pde: legal = up && hold_reg == 10'h000 &&
                       mrd_reg == 10'h000;
      cmd_sre: legal = up && hold_reg == 10'h000 && mrd_reg == 10'h000 &&
                       bst_reg == 3'h0 &&
                       open_reg == 8'h00 &&
                       xs_reg >= `SCK_TXS_NCK;
      cmd_pdx: legal = (pst_reg == cs_pd) && hold_reg == 10'h000;
      cmd_srx: legal = (pst_reg == cs_sr) &&
                       hold_reg == 10'h000;
      cmd_rd:  legal = up && bst_reg == 3'h0 &&
                       xs_reg >= `SCK_TXSDLL_NCK;
      cmd_wr:  legal = up && bst_reg == 3'h0 &&
                       xs_reg >= `SCK_TWRSRX_NCK;
      cmd_mrs, cmd_ref, cmd_pre, cmd_act, cmd_zq:
               legal = up && xs_reg >= `SCK_TXS_NCK;
      default: legal = 1'b0;
    endcase
  end

  assign take = req_valid && legal;

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rst_n_reg <= 1'b0;
      cke_reg   <= 1'b1;
      cs_n_reg  <= 1'b1;
      rcw_reg   <= 3'h7;
      ba_reg    <= 3'h0;
      addr_reg  <= 15'h0000;
      odt_reg   <= 1'b0;
    end else begin
      rst_n_reg <= 1'b1;
      cs_n_reg  <= 1'b1;
      rcw_reg   <= 3'h7;
      odt_reg   <= req_odt && up && xs_reg >= `SCK_TXSDLL_NCK;
      if (take && (req_cmd == cmd_pde || req_cmd == cmd_sre))
        cke_reg <= 1'b0;
      if (take && (req_cmd == cmd_pdx || req_cmd == cmd_srx))
        cke_reg <= 1'b1;
      // Power-down and exits go out as deselect
      if (take && !(req_cmd inside {cmd_pde, cmd_pdx, cmd_srx,
                                    cmd_nop})) begin
        cs_n_reg <= 1'b0;
        rcw_reg  <= (req_cmd == cmd_sre) ? 3'h1 : req_cmd[2:0];
        ba_reg   <= req_ba;
        addr_reg <= req_addr;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timing trackers and power state
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pst_reg  <= cs_up;
      hold_reg <= 10'h000;
      xs_reg   <= `SCK_XS_CAP;
      mrd_reg  <= 10'h000;
      bst_reg  <= 3'h0;
      open_reg <= 8'h00;
      ack_reg  <= 1'b0;
      rej_reg  <= 1'b0;
    end else begin
      ack_reg <= take;
      rej_reg <= req_valid && !legal;
      if (take && cke_cmd)
        hold_reg <= `SCK_TCKE_NCK - 10'h001;
      else if (hold_reg != 10'h000)
        hold_reg <= hold_reg - 10'h001;
      if (take && req_cmd == cmd_srx)
        xs_reg <= 10'h000;
      else if (xs_reg != `SCK_XS_CAP)
        xs_reg <= xs_reg + 10'h001;
      if (take && req_cmd == cmd_mrs)
        mrd_reg <= (`SCK_TMOD_NCK > `SCK_TMRD_NCK) ?
                   `SCK_TMOD_NCK : `SCK_TMRD_NCK;
      else if (mrd_reg != 10'h000)
        mrd_reg <= mrd_reg - 10'h001;
      if (take && (req_cmd == cmd_rd || req_cmd == cmd_wr))
        bst_reg <= `SCK_BL8_NCK;
      else if (bst_reg != 3'h0)
        bst_reg <= bst_reg - 3'h1;
      if (take && req_cmd == cmd_act)
        open_reg <= open_reg | (8'h01 << req_ba);
      if (take && req_cmd == cmd_pre)
        open_reg <= req_addr[`SCK_AP_BIT] ? 8'h00 :
                    (open_reg & ~(8'h01 << req_ba));
      if (take) begin
        case (req_cmd)
          cmd_pde: pst_reg <= cs_pd;
          cmd_sre: pst_reg <= cs_sr;
          cmd_pdx, cmd_srx: pst_reg <= cs_up;
          default: pst_reg <= pst_reg;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mem.reset_n = rst_n_reg;
  assign mem.cke     = cke_reg;
  assign mem.cs_n    = cs_n_reg;
  assign mem.ras_n   = rcw_reg[2];
  assign mem.cas_n   = rcw_reg[1];
  assign mem.we_n    = rcw_reg[0];
  assign mem.odt     = odt_reg;
  assign mem.ba      = ba_reg;
  assign mem.addr    = addr_reg;
  assign ack_o       = ack_reg;
  assign rej_o       = rej_reg;
  assign pstate_o    = pst_reg;

endmodule // sck_ctl

// File: sck_chk.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Power-state and burst checks on the link
// ------------------------------------------------------------
module sck_chk (
  input logic                  clock,
  input logic                  nrst,
  input logic                  reset_n,
  input logic                  cke,
  input logic                  cs_n,
  input logic                  ras_n,
  input logic                  cas_n,
  input logic                  we_n,
  input sck_pkg::sck_dstate_t  state_o,
  input logic [7:0]            bank_open_o,
  input logic [2:0]            burst_left_o,
  input logic                  idle_o,
  input logic                  odt_en_o
);
  import sck_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst || !reset_n);
  wire nop_w = cs_n | (ras_n & cas_n & we_n);
  wire ref_w = !cs_n & !ras_n & !cas_n & we_n;
  wire lowp = state_o inside {st_pd_pre, st_pd_act, st_self_ref};
  sequence tail_s;
    burst_left_o == 3'h1 ##1 burst_left_o == 3'h0;
  endsequence
  a_sr_entry: assert property (
    state_o == st_idle && idle_o && $past(cke) && !cke && ref_w
    |=> state_o == st_self_ref) else $error("sr entry");
  a_sr_exit: assert property (
    state_o == st_self_ref && cke |=> state_o == st_idle)
    else $error("sr exit");
  a_low_hold: assert property (
    lowp && !cke |=> $stable(state_o) && $stable(bank_open_o))
    else $error("low power hold");
  a_pd_exit: assert property (
    state_o == st_pd_act && cke |=> state_o == st_active)
    else $error("pd exit");
  a_pdp_exit: assert property (
    state_o == st_pd_pre && cke |=> state_o == st_idle)
    else $error("pd pre exit");
  a_pd_entry: assert property (
    state_o == st_active && $past(cke) && !cke && nop_w
    |=> state_o == st_pd_act) else $error("pd entry");
  a_burst_tail: assert property (
    burst_left_o == 3'h2 |=> tail_s) else $error("burst cut");
  a_odt_off: assert property (
    state_o == st_self_ref |-> !odt_en_o) else $error("odt in sr");
  a_nop_keep: assert property (
    state_o == st_active && cke && $past(cke) && nop_w
    |=> state_o == st_active && $stable(bank_open_o))
    else $error("nop changed state");
endmodule // sck_chk

// File: sck_test.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Controller to device bench
// ------------------------------------------------------------
module sck_test;
  import sck_pkg::*;
  logic        clock = 0, nrst = 0, req_valid = 0, req_odt = 1;
  sck_cmd_t    req_cmd = cmd_nop;
  logic [2:0]  req_ba = '0, burst_left_o;
  logic [14:0] req_addr = '0;
  logic        ack_o, rej_o, idle_o, odt_en_o, sref_tick_o;
  sck_dstate_t state_o;
  sck_cstate_t pstate_o;
  logic [7:0]  bank_open_o;
  int          mismatches = 0, check_count = 0, tick_count = 0;
  always #2.5 clock = ~clock;
  always @(posedge clock)
    if (sref_tick_o === 1'b1)
      tick_count++;
  sck_if mem ();
  sck_ctl i_sck_ctl (.clock(clock), .nrst(nrst), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_ba(req_ba), .req_addr(req_addr),
    .req_odt(req_odt), .ack_o(ack_o), .rej_o(rej_o), .pstate_o(pstate_o),
    .mem(mem));
  sck_dev i_sck_dev (.clock(clock), .nrst(nrst), .mem(mem),
    .state_o(state_o), .bank_open_o(bank_open_o), .idle_o(idle_o),
    .burst_left_o(burst_left_o), .odt_en_o(odt_en_o),
    .sref_tick_o(sref_tick_o));
  sck_chk i_sck_chk (.clock(clock), .nrst(nrst), .reset_n(mem.reset_n),
    .cke(mem.cke), .cs_n(mem.cs_n), .ras_n(mem.ras_n), .cas_n(mem.cas_n),
    .we_n(mem.we_n), .state_o(state_o), .bank_open_o(bank_open_o),
    .burst_left_o(burst_left_o), .idle_o(idle_o), .odt_en_o(odt_en_o));
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic st(input sck_dstate_t e);
    chk("state", 16'(e), 16'(state_o));
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic req(input sck_cmd_t c, input logic [2:0] b,
                     input logic [14:0] a, input logic ok);
    int n;
    @(posedge clock);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_ba <= b;
    req_addr <= a;
    @(posedge clock);
    req_valid <= 1'b0;
    #1;
    for (n = 0; n < 4 && !(ack_o || rej_o); n++)
      wait_n(1);
    if (n < 4) begin
      chk("ack", 16'(ok), 16'(ack_o));
      wait_n(1);
    end else begin
      mismatches++;
      final_report();
    end
  endtask
  task automatic burst(input int n);
    for (int i = n; i >= 0; i--) begin
      chk("burst", 16'(i), 16'(burst_left_o));
      if (i > 0)
        wait_n(1);
    end
    st(st_active);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    wait_n(1);
    chk("reset_n", 16'h0001, 16'(mem.reset_n));
    req(cmd_mrs, 3'h0, 15'h0002, 1'b1);
    req(cmd_pde, 3'h0, 15'h0000, 1'b0);
    wait_n(14);
    req(cmd_act, 3'h1, 15'h0000, 1'b1);
    chk("banks", 16'h0002, 16'(bank_open_o));
    req(cmd_rd, 3'h1, 15'h0000, 1'b1);
    st(st_read);
    burst(2);
    req(cmd_sre, 3'h0, 15'h0000, 1'b0);
    req(cmd_pde, 3'h0, 15'h0000, 1'b1);
    st(st_pd_act);
    chk("pstate", 16'(cs_pd), 16'(pstate_o));
    req(cmd_act, 3'h2, 15'h0000, 1'b0);
    st(st_pd_act);
    req(cmd_pdx, 3'h0, 15'h0000, 1'b1);
    st(st_active);
    chk("ticks", 16'h0000, 16'(tick_count));
    wait_n(4);
    req(cmd_pre, 3'h0, 15'h0400, 1'b1);
    wait_n(10);
    chk("idle", 16'h0001, 16'(idle_o));
    req(cmd_ref, 3'h0, 15'h0000, 1'b1);
    st(st_refresh);
    req(cmd_pde, 3'h0, 15'h0000, 1'b1);
    st(st_pd_pre);
    req(cmd_pdx, 3'h0, 15'h0000, 1'b1);
    st(st_idle);
    wait_n(42);
    chk("idle", 16'h0001, 16'(idle_o));
    req(cmd_sre, 3'h0, 15'h0000, 1'b1);
    st(st_self_ref);
    wait_n(20);
    chk("odt", 16'h0000, 16'(odt_en_o));
    req(cmd_srx, 3'h0, 15'h0000, 1'b1);
    st(st_idle);
    chk("ticks", 16'h0001, 16'(tick_count));
    req(cmd_act, 3'h0, 15'h0000, 1'b0);
    wait_n(25);
    req(cmd_act, 3'h0, 15'h0000, 1'b1);
    req(cmd_wr, 3'h0, 15'h0000, 1'b0);
    wait_n(512);
    req(cmd_wr, 3'h0, 15'h0000, 1'b1);
    chk("odt", 16'h0001, 16'(odt_en_o));
    @(posedge clock);
    req_odt <= 1'b0;
    wait_n(2);
    chk("odt", 16'h0000, 16'(odt_en_o));
    final_report();
  end
endmodule // sck_test
